// [inc/pc_fsm_params.svh]
// offsets, field positions, reset values and codes of the power condition block
`ifndef PC_FSM_PARAMS_SVH
`define PC_FSM_PARAMS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PC_ADDR_W 8
`define PC_OFF_CMD 8'h00
`define PC_OFF_STBY_TMR 8'h04
`define PC_OFF_IDLE_TMR 8'h08
`define PC_OFF_STATUS 8'h0C
`define PC_OFF_CONFIG 8'h10

// ---------------------------------------------------------------
// command register fields
// ---------------------------------------------------------------
`define PC_CMD_START_BIT 0
`define PC_CMD_PC_LSB 4
`define PC_CMD_PC_MSB 7
`define PC_CMD_IMMEDIATE_RETURN_BIT_BIT 8
`define PC_CMD_SSU_BIT 9
`define PC_CMD_NEED_ACT_BIT 10
`define PC_CMD_NEED_IDLE_BIT 11
`define PC_CMD_MEDIA_BIT 12

// ---------------------------------------------------------------
// power condition field codes
// ---------------------------------------------------------------
`define PC_CODE_START 4'h0
`define PC_CODE_ACTIVE 4'h1
`define PC_CODE_IDLE 4'h2
`define PC_CODE_STANDBY 4'h3
`define PC_CODE_FORCE_IDLE 4'hA
`define PC_CODE_FORCE_STANDBY 4'hB

// ---------------------------------------------------------------
// config register fields and reset values
// ---------------------------------------------------------------
`define PC_CFG_START_STOPPED_BIT 0
`define PC_CFG_SAS_BIT 1
`define PC_CFG_RESET 32'h0000_0002
`define PC_TMR_RESET 32'h0000_0000

// ---------------------------------------------------------------
// status register fields and sense values
// ---------------------------------------------------------------
`define PC_STS_STATE_LSB 0
`define PC_STS_CPL_LSB 4
`define PC_STS_KEY_LSB 8
`define PC_STS_ASC_LSB 16
`define PC_STS_ASCQ_LSB 24
`define PC_SENSE_KEY_NOT_READY 4'h2
`define PC_ASC_NOT_READY 8'h04
`define PC_ASCQ_NEED_SPINUP 8'h11

// ---------------------------------------------------------------
// bus answers
// ---------------------------------------------------------------
`define PC_RESP_OKAY 2'h0
`define PC_RESP_DECERR 2'h3

`endif

// [inc/pc_fsm_pkg.sv]
// types of the power condition block
package pc_fsm_pkg;

  typedef enum logic [2:0] {
    powered_on_state = 3'h0,
    active_wait_state = 3'h1,
    active_state = 3'h3,
    idle_state = 3'h2,
    standby_state = 3'h6,
    stopped_state = 3'h7,
    idle_wait_state = 3'h5
  } pc_state_t;

  typedef enum logic [1:0] {
    cpl_none = 2'h0,
    cpl_good = 2'h1,
    cpl_check = 2'h2,
    cpl_pending = 2'h3
  } cpl_status_t;

endpackage : pc_fsm_pkg

// [rtl/condition_timer.sv]
// reloadable power condition timer with a one-cycle expiry pulse
`timescale 1ns/100ps
`default_nettype none

module condition_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic restart,
  input wire logic [31:0] reload,
  // result
  output logic expired
);

  logic [31:0] count_ff;
  logic [31:0] nxt_count;
  logic armed_ff;
  logic nxt_armed;
  logic expired_ff;
  logic nxt_expired;

  // zero reload disables the timer; expiry fires once per arming
  always_comb begin
    nxt_count = count_ff;
    nxt_armed = armed_ff;
    nxt_expired = 1'b0;
    if (restart || !run || reload == 32'h0000_0000) begin
      nxt_count = reload;
      nxt_armed = (reload != 32'h0000_0000);
    end else if (armed_ff) begin
      if (count_ff <= 32'h0000_0001) begin
        nxt_armed = 1'b0;
        nxt_expired = 1'b1;
      end else begin
        nxt_count = count_ff - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_ff <= 32'h0000_0000;
      armed_ff <= 1'b0;
      expired_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      armed_ff <= nxt_armed;
      expired_ff <= nxt_expired;
    end
  end

  assign expired = expired_ff;

endmodule : condition_timer

`default_nettype wire

// [rtl/power_condition_fsm.sv]
// power condition state machine with idle wait handling and an AXI4-Lite register slave
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pc_fsm_params.svh"

module power_condition_fsm
  import pc_fsm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // link-side pins
  input wire logic spinup_notify_in,
  input wire logic no_extra_power_in,
  // state outputs
  output logic [2:0] pc_state,
  output logic spindle_run,
  output logic media_ready,
  output logic completion_hold
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == `PC_OFF_CMD) || (a == `PC_OFF_STBY_TMR) || (a == `PC_OFF_IDLE_TMR) ||
           (a == `PC_OFF_STATUS) || (a == `PC_OFF_CONFIG);
  endfunction : addr_mapped

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] notify_sync_ff;
  logic [1:0] power_sync_ff;
  logic [2:0] nxt_notify_sync;
  logic [1:0] nxt_power_sync;
  logic notify_seen;

  always_comb begin
    nxt_notify_sync = {notify_sync_ff[1:0], spinup_notify_in};
    nxt_power_sync = {power_sync_ff[0], no_extra_power_in};
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      notify_sync_ff <= 3'h0;
      power_sync_ff <= 2'h0;
    end else begin
      notify_sync_ff <= nxt_notify_sync;
      power_sync_ff <= nxt_power_sync;
    end
  end

  // spin-up permission: notify edge or no extra power draw
  assign notify_seen = (notify_sync_ff[1] && !notify_sync_ff[2]) || power_sync_ff[1];

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_held_ff, w_held_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid;
  logic nxt_aw_held, nxt_w_held;
  logic [7:0] nxt_awaddr;
  logic [31:0] nxt_wdata, nxt_rdata;
  logic [3:0] nxt_wstrb;
  logic [1:0] nxt_bresp, nxt_rresp;
  logic wr_fire;
  logic [31:0] status_word, config_ff, stby_reload_ff, idle_reload_ff;

  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;

  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held = w_held_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_held = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_held = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (wr_fire) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = addr_mapped(awaddr_ff) ? `PC_RESP_OKAY : `PC_RESP_DECERR;
    end
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = addr_mapped(s_axi_araddr) ? `PC_RESP_OKAY : `PC_RESP_DECERR;
      case (s_axi_araddr)
        `PC_OFF_STBY_TMR: nxt_rdata = stby_reload_ff;
        `PC_OFF_IDLE_TMR: nxt_rdata = idle_reload_ff;
        `PC_OFF_STATUS: nxt_rdata = status_word;
        `PC_OFF_CONFIG: nxt_rdata = config_ff;
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    nxt_awready = !nxt_aw_held;
    nxt_wready = !nxt_w_held;
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      arready_ff <= 1'b0;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `PC_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `PC_RESP_OKAY;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      arready_ff <= nxt_arready;
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // ---------------------------------------------------------------
  // power condition machine and status
  // ---------------------------------------------------------------
  pc_state_t state_ff, nxt_state;
  cpl_status_t cpl_ff, nxt_cpl;
  pc_state_t target_ff, nxt_target;
  logic [31:0] nxt_config, nxt_stby_reload, nxt_idle_reload;
  logic spindle_ff, ready_ff, hold_ff;
  logic cmd_go, ssu, stop_req, start_req, act_req, idle_req, stby_req;
  logic need_act, need_idle, media_cmd, immediate_return_bit, sas;
  logic stby_exp, idle_exp, tmr_run, tmr_restart;
  logic [3:0] pc_code;

  assign cmd_go = wr_fire && (awaddr_ff == `PC_OFF_CMD) && (wstrb_ff[1:0] != 2'h0);
  assign pc_code = wdata_ff[`PC_CMD_PC_MSB:`PC_CMD_PC_LSB];
  assign ssu = cmd_go && wdata_ff[`PC_CMD_SSU_BIT];
  assign immediate_return_bit = wdata_ff[`PC_CMD_IMMEDIATE_RETURN_BIT_BIT];
  assign stop_req = ssu && pc_code == `PC_CODE_START && !wdata_ff[`PC_CMD_START_BIT];
  assign start_req = ssu && pc_code == `PC_CODE_START && wdata_ff[`PC_CMD_START_BIT];
  assign act_req = ssu && pc_code == `PC_CODE_ACTIVE;
  assign idle_req = ssu && (pc_code == `PC_CODE_IDLE || pc_code == `PC_CODE_FORCE_IDLE);
  assign stby_req = ssu && (pc_code == `PC_CODE_STANDBY || pc_code == `PC_CODE_FORCE_STANDBY);
  assign need_act = cmd_go && !ssu && wdata_ff[`PC_CMD_NEED_ACT_BIT];
  assign need_idle = cmd_go && !ssu && wdata_ff[`PC_CMD_NEED_IDLE_BIT];
  assign media_cmd = cmd_go && !ssu && wdata_ff[`PC_CMD_MEDIA_BIT];
  assign sas = config_ff[`PC_CFG_SAS_BIT];
  assign tmr_run = (state_ff != standby_state) && (state_ff != stopped_state);
  assign tmr_restart = (nxt_state != state_ff) || cmd_go;

  assign status_word = {`PC_ASCQ_NEED_SPINUP & {8{cpl_ff == cpl_check}},
                        `PC_ASC_NOT_READY & {8{cpl_ff == cpl_check}},
                        4'h0, `PC_SENSE_KEY_NOT_READY & {4{cpl_ff == cpl_check}},
                        2'h0, cpl_ff, hold_ff, state_ff};

  condition_timer u_stby_tmr (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(tmr_run),
    .restart(tmr_restart),
    .reload(stby_reload_ff),
    .expired(stby_exp)
  );

  condition_timer u_idle_tmr (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(tmr_run),
    .restart(tmr_restart),
    .reload(idle_reload_ff),
    .expired(idle_exp)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_cpl = cpl_ff;
    nxt_target = target_ff;
    nxt_config = config_ff;
    nxt_stby_reload = stby_reload_ff;
    nxt_idle_reload = idle_reload_ff;
    if (wr_fire && awaddr_ff == `PC_OFF_CONFIG) begin
      nxt_config = merge_bytes(config_ff, wdata_ff, wstrb_ff) & 32'h0000_0003;
    end
    if (wr_fire && awaddr_ff == `PC_OFF_STBY_TMR) begin
      nxt_stby_reload = merge_bytes(stby_reload_ff, wdata_ff, wstrb_ff);
    end
    if (wr_fire && awaddr_ff == `PC_OFF_IDLE_TMR) begin
      nxt_idle_reload = merge_bytes(idle_reload_ff, wdata_ff, wstrb_ff);
    end
    case (state_ff)
      powered_on_state: begin
        nxt_state = config_ff[`PC_CFG_START_STOPPED_BIT] ? stopped_state :
                    (sas ? active_wait_state : active_state);
      end
      active_state: begin
        if (stop_req) nxt_state = stopped_state;
        else if (stby_req || stby_exp) nxt_state = standby_state;
        else if (idle_req || idle_exp) nxt_state = idle_state;
      end
      idle_state: begin
        if (stop_req) nxt_state = stopped_state;
        else if (stby_req || stby_exp) nxt_state = standby_state;
        else if (start_req || act_req || need_act) nxt_state = active_state;
      end
      standby_state: begin
        if (stop_req) nxt_state = stopped_state;
        else if (start_req || act_req || need_act) nxt_state = sas ? active_wait_state : active_state;
        else if (idle_req || need_idle) nxt_state = sas ? idle_wait_state : idle_state;
      end
      stopped_state: begin
        if (stby_req) nxt_state = standby_state;
        else if (start_req || act_req) nxt_state = sas ? active_wait_state : active_state;
        else if (idle_req) nxt_state = sas ? idle_wait_state : idle_state;
      end
      active_wait_state: begin
        if (stop_req) nxt_state = stopped_state;
        else if (stby_req || stby_exp) nxt_state = standby_state;
        else if (notify_seen) nxt_state = active_state;
        else if (idle_req || idle_exp) nxt_state = idle_wait_state;
      end
      idle_wait_state: begin
        if (stop_req) nxt_state = stopped_state;
        else if (stby_req || stby_exp) nxt_state = standby_state;
        else if (act_req || need_act) nxt_state = active_wait_state;
        else if (notify_seen) nxt_state = idle_state;
      end
      default: nxt_state = powered_on_state;
    endcase
    // completion of the command just taken
    if (cmd_go) begin
      if (media_cmd && (state_ff == idle_wait_state || state_ff == active_wait_state)) begin
        nxt_cpl = cpl_check;
      end else if (ssu && !immediate_return_bit && nxt_state == active_wait_state) begin
        nxt_cpl = cpl_pending;
        nxt_target = active_state;
      end else if (ssu && !immediate_return_bit && nxt_state == idle_wait_state) begin
        nxt_cpl = cpl_pending;
        nxt_target = idle_state;
      end else begin
        nxt_cpl = cpl_good;
      end
    end else if (cpl_ff == cpl_pending) begin
      if (state_ff == target_ff) nxt_cpl = cpl_good;
      else if (state_ff != active_wait_state && state_ff != idle_wait_state) nxt_cpl = cpl_check;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= powered_on_state;
      cpl_ff <= cpl_none;
      target_ff <= active_state;
      config_ff <= `PC_CFG_RESET;
      stby_reload_ff <= `PC_TMR_RESET;
      idle_reload_ff <= `PC_TMR_RESET;
      spindle_ff <= 1'b0;
      ready_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cpl_ff <= nxt_cpl;
      target_ff <= nxt_target;
      config_ff <= nxt_config;
      stby_reload_ff <= nxt_stby_reload;
      idle_reload_ff <= nxt_idle_reload;
      // spindle runs only in active and idle
      spindle_ff <= (nxt_state == active_state) || (nxt_state == idle_state);
      ready_ff <= (nxt_state == active_state) || (nxt_state == idle_state);
      hold_ff <= (nxt_cpl == cpl_pending);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign pc_state = state_ff;
  assign spindle_run = spindle_ff;
  assign media_ready = ready_ff;
  assign completion_hold = hold_ff;

endmodule : power_condition_fsm

`default_nettype wire

// [tb/idle_wait_power_condition_fsm_bench.sv]
// self-checking bench for the idle wait power condition machine
`timescale 1ns/100ps
`default_nettype none
`include "pc_fsm_params.svh"

module idle_wait_power_condition_fsm_bench import pc_fsm_pkg::*;;
  logic ref_clk = 1'b0, rst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0, notify_delay = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd, want;
  logic spinup_notify_in, no_extra_power_in, spindle_run, media_ready, completion_hold;
  logic [2:0] pc_state;
  logic notify_req = 1'b0, power_free = 1'b0;
  int failures = 0, checks_done = 0, cycles = 0;
  logic [31:0] ent [3] = '{32'h0000_0320, 32'h0000_03A0, 32'h0000_0800};
  logic [31:0] trig [7] = '{32'h0000_0330, 32'h0000_03B0, 32'h0000_0300, 32'h0000_0400,
    32'h0000_0310, 32'h0000_0700, 32'h0000_0730};
  pc_state_t dst [7] = '{standby_state, standby_state, stopped_state, active_wait_state,
    active_wait_state, stopped_state, standby_state};

  power_condition_fsm i_dut (.ref_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .spinup_notify_in, .no_extra_power_in,
    .pc_state, .spindle_run, .media_ready, .completion_hold);
  initiator_model i_host (.ref_clk, .notify_req, .notify_delay, .power_free,
    .spinup_notify_in, .no_extra_power_in);

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // --------------------
  // tasks
  // --------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic check_state(input pc_state_t s);
    int n;
    n = 0;
    while (pc_state !== s && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    check({29'h0, pc_state}, {29'h0, s});
  endtask : check_state

  task automatic axi_write(input logic [7:0] addr, input logic [31:0] data);
    @(posedge ref_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= addr;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= data;
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] addr);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= addr;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic goto_wait(input logic [31:0] entry);
    axi_write(`PC_OFF_CMD, 32'h0000_0330);
    check_state(standby_state);
    axi_write(`PC_OFF_CMD, entry);
    check_state(idle_wait_state);
  endtask : goto_wait

  task automatic notify(input logic [3:0] d);
    @(posedge ref_clk);
    notify_delay <= d;
    notify_req <= 1'b1;
    @(posedge ref_clk);
    notify_req <= 1'b0;
  endtask : notify

  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      test_done();
    end
  end
  // --------------------
  // tests
  // --------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    check_state(active_wait_state);
    axi_read(`PC_OFF_CONFIG);
    check(rd, `PC_CFG_RESET);
    axi_read(`PC_OFF_STBY_TMR);
    check(rd, `PC_TMR_RESET);
    axi_read(8'h20);
    check(rd, 32'h0000_0000);
    check({30'h0, rsp}, {30'h0, `PC_RESP_DECERR});
    axi_write(8'h24, 32'hFFFF_FFFF);
    check({30'h0, rsp}, {30'h0, `PC_RESP_DECERR});
    goto_wait(32'h0000_0320);
    check({30'h0, spindle_run, media_ready}, 32'h0);
    axi_write(`PC_OFF_CMD, 32'h0000_1000);
    axi_read(`PC_OFF_STATUS);
    want = {`PC_ASCQ_NEED_SPINUP, `PC_ASC_NOT_READY, 4'h0, `PC_SENSE_KEY_NOT_READY, 2'h0,
      cpl_check, 1'b0, idle_wait_state};
    check(rd, want);
    notify(4'h1);
    check_state(idle_state);
    check({30'h0, spindle_run, media_ready}, 32'h3);
    axi_write(`PC_OFF_CMD, 32'h0000_1000);
    axi_read(`PC_OFF_STATUS);
    check(rd, {24'h0, 2'h0, cpl_good, 1'b0, idle_state});
    for (int i = 0; i < 7; i++) begin
      goto_wait(ent[i % 3]);
      axi_write(`PC_OFF_CMD, trig[i]);
      check_state(dst[i]);
    end
    goto_wait(32'h0000_0320);
    axi_write(`PC_OFF_CMD, 32'h0000_0210);
    check_state(active_wait_state);
    axi_read(`PC_OFF_STATUS);
    check(rd, {24'h0, 2'h0, cpl_pending, 1'b1, active_wait_state});
    check({31'h0, completion_hold}, 32'h0000_0001);
    notify(4'h9);
    check_state(active_state);
    axi_read(`PC_OFF_STATUS);
    check(rd, {24'h0, 2'h0, cpl_good, 1'b0, active_state});
    check({31'h0, completion_hold}, 32'h0000_0000);
    goto_wait(32'h0000_03A0);
    power_free <= 1'b1;
    check_state(idle_state);
    power_free <= 1'b0;
    // timer arms on the next state change or command write, so load it before entering idle wait
    axi_write(`PC_OFF_STBY_TMR, 32'h0000_000A);
    goto_wait(32'h0000_0800);
    check_state(standby_state);
    axi_write(`PC_OFF_STBY_TMR, 32'h0000_0000);
    axi_write(`PC_OFF_CONFIG, 32'h0000_0000);
    axi_write(`PC_OFF_CMD, 32'h0000_0320);
    check_state(idle_state);
    test_done();
  end
endmodule : idle_wait_power_condition_fsm_bench

`default_nettype wire

// [tb/initiator_model.sv]
// initiator side: spin-up notify pulses and the power permission level
`timescale 1ns/100ps
`default_nettype none

module initiator_model (
  // clock
  input wire logic ref_clk,
  // requests from the bench
  input wire logic notify_req,
  input wire logic [3:0] notify_delay,
  input wire logic power_free,
  // device pins
  output logic spinup_notify_in,
  output logic no_extra_power_in
);
  logic [4:0] cnt_ff = 5'h00;
  always @(posedge ref_clk) begin
    if (notify_req) cnt_ff <= {1'b0, notify_delay} + 5'h04;
    else if (cnt_ff != 5'h00) cnt_ff <= cnt_ff - 5'h01;
  end
  // four-cycle notify after a chosen delay, low otherwise
  assign spinup_notify_in = (cnt_ff != 5'h00) && (cnt_ff <= 5'h04);
  assign no_extra_power_in = power_free;
endmodule : initiator_model

`default_nettype wire

// [tb/power_condition_fsm_props.sv]
// assertions on the ports of the power condition machine
`timescale 1ns/100ps
`default_nettype none

module power_condition_fsm_props
  import pc_fsm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus handshake
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // pins and state
  input wire logic spinup_notify_in,
  input wire logic no_extra_power_in,
  input wire logic [2:0] pc_state,
  input wire logic spindle_run,
  input wire logic media_ready,
  input wire logic completion_hold
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // --------------------
  // state and write response rules
  // --------------------
  chk_wait_media_off:
    assert property (pc_state == idle_wait_state |-> !spindle_run && !media_ready)
    else $error("spindle or media on in idle wait");
  chk_spin_states:
    assert property (spindle_run |-> pc_state inside {active_state, idle_state})
    else $error("spindle running outside active or idle");
  chk_idle_spins:
    assert property (pc_state == idle_state |-> spindle_run && media_ready)
    else $error("idle without spindle or media ready");
  chk_wait_exits:
    assert property ($past(pc_state) == idle_wait_state && pc_state != idle_wait_state |->
      pc_state inside {idle_state, standby_state, stopped_state, active_wait_state})
    else $error("illegal exit from idle wait");
  chk_wait_entry:
    assert property (pc_state == idle_wait_state && $past(pc_state) != idle_wait_state |->
      $past(pc_state) inside {standby_state, stopped_state, active_wait_state})
    else $error("illegal entry to idle wait");
  chk_notify_leaves:
    assert property ($rose(spinup_notify_in) && pc_state == idle_wait_state |->
      ##[1:8] pc_state == idle_state)
    else $error("notify did not reach idle");
  chk_power_leaves:
    assert property (no_extra_power_in && pc_state == idle_wait_state |->
      ##[1:8] pc_state != idle_wait_state)
    else $error("free power did not leave idle wait");
  chk_hold_kept:
    assert property (completion_hold && pc_state == active_wait_state && s_axi_awready &&
      s_axi_wready && !s_axi_bvalid |=> completion_hold || pc_state != active_wait_state)
    else $error("good completion released before active");
  chk_bresp_held:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  cov_notify: cover property (pc_state == idle_wait_state ##1 pc_state == idle_state);
  cov_standby: cover property (pc_state == idle_wait_state ##1 pc_state == standby_state);
  cov_hold: cover property ($rose(completion_hold));
endmodule : power_condition_fsm_props

bind power_condition_fsm power_condition_fsm_props i_props (.ref_clk, .rst, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .spinup_notify_in,
  .no_extra_power_in, .pc_state, .spindle_run, .media_ready, .completion_hold);

`default_nettype wire
